// ---- cspc_top.sv ----
// capture front end sync, clock reference and power control
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "cspc_defines.svh"
module cspc_top import cspc_pkg::*; #(
    parameter int ACT_CYCLES = `CSPC_ACT_CYCLES,
    parameter int DW         = 24
) (
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          hsel_in,
    input  wire logic [31:0]   haddr_in,
    input  wire logic [1:0]    htrans_in,
    input  wire logic          hwrite_in,
    input  wire logic [2:0]    hsize_in,
    input  wire logic [31:0]   hwdata_in,
    input  wire logic          hready_in,
    output logic      [31:0]   hrdata_out,
    output logic               hreadyout_out,
    output logic               hresp_out,
    input  wire logic          hsync_in,
    input  wire logic          vsync_in,
    input  wire logic          green_embedded_sync_in,
    input  wire logic          hold_in,
    input  wire logic [DW-1:0] pixel_in,
    output logic      [DW-1:0] pixel_out,
    output logic               pixel_valid_out,
    output logic               output_data_clock_out,
    output logic               sync_output_pulse_out,
    output logic               pll_ref_out,
    output logic      [12:0]   pll_mult_out,
    output logic      [1:0]    oscillator_range_code_out,
    output logic      [2:0]    pump_code_out,
    output logic      [4:0]    phase_step_out,
    output logic      [1:0]    power_state_out,
    output logic               core_power_en_out,
    output logic               slicer_power_en_out,
    output logic               irq_out
);
    localparam int AW = $clog2(ACT_CYCLES + 1);
    localparam int NI = `CSPC_NUM_IRQ;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0]    div_msb_q;
    logic [3:0]    div_lsb_q;
    logic [4:0]    pll_ctl_q;
    logic [4:0]    phase_q;
    logic [7:0]    width_q;
    logic [7:0]    sync_ctl_q;
    logic [7:0]    pwr_ctl_q;
    logic [NI-1:0] irq_stat_q;
    logic [NI-1:0] irq_mask_q;
    logic          wr_pend_q;
    logic [7:0]    wr_idx_q;
    logic          rd_wait_q;
    logic [7:0]    rd_idx_q;
    logic [31:0]   hrdata_q;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic        acc_w;
    logic        wr_w;
    logic [7:0]  wd_w;
    logic [31:0] rd_word_w;
    logic        wr_stat_w;

    assign acc_w  = hsel_in && hready_in && htrans_in[1];
    assign wd_w   = hwdata_in[7:0];
    assign wr_w   = wr_pend_q;
    assign wr_stat_w = wr_w && (wr_idx_q == `CSPC_IDX_IRQ_STAT);

    // ----------------------------------------
    // sync inputs
    // ----------------------------------------
    logic [3:0] pins_s;
    logic [2:0] act_pin_w;
    logic       hs_s;
    logic       hold_s;

    cspc_sync_in #(
        .WIDTH (4)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in ({hold_in, green_embedded_sync_in, vsync_in, hsync_in}),
        .sync_out (pins_s)
    );

    assign act_pin_w = pins_s[2:0];
    assign hs_s      = pins_s[0];
    assign hold_s    = pins_s[3];

    // ----------------------------------------
    // activity detectors, one per sync input
    // ----------------------------------------
    logic [2:0] act_w;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_act
            logic          last_q;
            logic [AW-1:0] tmo_q;
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    last_q <= 1'b0;
                    tmo_q  <= '0;
                end else begin
                    last_q <= act_pin_w[gi];
                    if (last_q != act_pin_w[gi]) begin
                        tmo_q <= AW'(ACT_CYCLES);
                    end else if (tmo_q != '0) begin
                        tmo_q <= tmo_q - 1'b1;
                    end
                end
            end
            assign act_w[gi] = (tmo_q != '0);
        end
    endgenerate

    logic [7:0] status_w;
    logic       sync_det_w;
    logic       det_pol_q;

    // hsync, vsync and green sync activity at their status positions
    assign status_w = {act_w[0], 2'b00, act_w[1], det_pol_q,
                       1'b0, act_w[2], 1'b0};
    assign sync_det_w = status_w[`CSPC_BIT_ACT_HS]
                      | status_w[`CSPC_BIT_ACT_VS]
                      | status_w[`CSPC_BIT_ACT_GS];

    // ----------------------------------------
    // power state
    // ----------------------------------------
    cspc_power_type power_q;
    cspc_power_type power_d;
    logic           pwr_on_w;

    assign pwr_on_w = pwr_ctl_q[`CSPC_BIT_PWR_ON];
    // command first, then activity
    assign power_d = !pwr_on_w  ? CSPC_DOWN :
                     sync_det_w ? CSPC_FULL : CSPC_SEEK;

    assign power_state_out     = power_q;
    assign core_power_en_out   = (power_q == CSPC_FULL);
    // green slicer stays up in power-down but not in seek
    assign slicer_power_en_out = (power_q != CSPC_SEEK);

    // ----------------------------------------
    // incoming sync polarity
    // ----------------------------------------
    logic        hs_last_q;
    logic [11:0] run_q;
    logic [11:0] hi_len_q;
    logic [11:0] lo_len_q;
    logic        hs_rise_w;
    logic        hs_fall_w;
    logic        pol_new_w;

    assign hs_rise_w = hs_s && !hs_last_q;
    assign hs_fall_w = !hs_s && hs_last_q;
    // the pulse is the shorter phase of the line
    assign pol_new_w = (hi_len_q < lo_len_q);

    // ----------------------------------------
    // clock generator reference
    // ----------------------------------------
    logic       hold_act_w;
    logic       hs_ref_w;
    logic       ref_q;
    logic [11:0] div_w;

    assign hold_act_w = hold_s
                      ~^ sync_ctl_q[`CSPC_BIT_HOLD_POL];
    assign hs_ref_w   = sync_ctl_q[`CSPC_BIT_HS_POL] ? hs_rise_w
                                                     : hs_fall_w;
    assign div_w = ({div_msb_q, div_lsb_q} < `CSPC_DIV_MIN) ?
                   `CSPC_DIV_MIN : {div_msb_q, div_lsb_q};

    assign pll_ref_out = ref_q;
    assign pll_mult_out = {1'b0, div_w} + 13'h0001;
    assign oscillator_range_code_out = pll_ctl_q[4:3];
    assign pump_code_out  = pll_ctl_q[2:0];
    assign phase_step_out = phase_q;

    // ----------------------------------------
    // output pixel path
    // ----------------------------------------
    logic                   ck_q;
    logic                   tick_w;
    logic [DW-1:0]          pipe_q [`CSPC_PIPE_DEPTH];
    logic [2:0]             flush_q;
    logic                   lead_pend_q;
    logic [`CSPC_PIPE_DEPTH-1:0] lead_sr_q;
    logic                   lead_w;

    // data moves when the clock falls, so it rises mid-data
    assign tick_w = ck_q;
    assign output_data_clock_out = ck_q;
    assign pixel_out = pipe_q[`CSPC_PIPE_DEPTH-1];
    assign pixel_valid_out = (flush_q == 3'(`CSPC_PIPE_DEPTH));
    assign lead_w = det_pol_q ? hs_rise_w : hs_fall_w;

    cspc_pulse_gen #(
        .CW (8)
    ) u_pulse (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .tick_in        (tick_w),
        .start_in       (tick_w && lead_sr_q[`CSPC_PIPE_DEPTH-1]),
        .width_in       (width_q),
        .active_high_in (sync_ctl_q[`CSPC_BIT_OUT_POL]),
        .pulse_out      (sync_output_pulse_out)
    );

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic           det_last_q;
    logic [NI-1:0]  ev_w;

    assign ev_w = {pol_new_w != det_pol_q,
                   det_last_q && !sync_det_w,
                   !det_last_q && sync_det_w};
    assign irq_out = |(irq_stat_q & irq_mask_q);

    // ----------------------------------------
    // read mux, unmapped words read zero
    // ----------------------------------------
    always_comb begin
        rd_word_w = '0;
        case (rd_idx_q)
            `CSPC_IDX_DIV_MSB:  rd_word_w[7:0] = div_msb_q;
            `CSPC_IDX_DIV_LSB:  rd_word_w[7:0] = {div_lsb_q, 4'h0};
            `CSPC_IDX_PLL_CTL:  rd_word_w[7:0] = {pll_ctl_q, 3'h0};
            `CSPC_IDX_PHASE:    rd_word_w[7:0] = {phase_q, 3'h0};
            `CSPC_IDX_WIDTH:    rd_word_w[7:0] = width_q;
            `CSPC_IDX_SYNC_CTL: rd_word_w[7:0] = sync_ctl_q;
            `CSPC_IDX_PWR_CTL:  rd_word_w[7:0] = pwr_ctl_q;
            `CSPC_IDX_STATUS:   rd_word_w[7:0] = status_w;
            `CSPC_IDX_IRQ_STAT: rd_word_w[NI-1:0] = irq_stat_q;
            `CSPC_IDX_IRQ_MASK: rd_word_w[NI-1:0] = irq_mask_q;
            default:            rd_word_w = '0;
        endcase
    end

    assign hrdata_out    = hrdata_q;
    assign hreadyout_out = !rd_wait_q;
    assign hresp_out     = 1'b0;

    // ----------------------------------------
    // bus slave; one wait state on reads
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
            rd_wait_q <= 1'b0;
            rd_idx_q  <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            wr_pend_q <= acc_w && hwrite_in;
            rd_wait_q <= acc_w && !hwrite_in;
            if (acc_w) begin
                wr_idx_q <= haddr_in[9:2];
                rd_idx_q <= haddr_in[9:2];
            end
            if (rd_wait_q) begin
                hrdata_q <= rd_word_w;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_msb_q  <= `CSPC_RST_DIV_MSB;
            div_lsb_q  <= 4'(`CSPC_RST_DIV_LSB >> 4);
            pll_ctl_q  <= 5'(`CSPC_RST_PLL_CTL >> 3);
            phase_q    <= 5'(`CSPC_RST_PHASE >> 3);
            width_q    <= `CSPC_RST_WIDTH;
            sync_ctl_q <= `CSPC_RST_SYNC_CTL;
            pwr_ctl_q  <= `CSPC_RST_PWR_CTL;
            irq_mask_q <= '0;
        end else if (wr_w) begin
            case (wr_idx_q)
                `CSPC_IDX_DIV_MSB:  div_msb_q  <= wd_w;
                `CSPC_IDX_DIV_LSB:  div_lsb_q  <= wd_w[7:4];
                `CSPC_IDX_PLL_CTL:  pll_ctl_q  <= wd_w[7:3];
                `CSPC_IDX_PHASE:    phase_q    <= wd_w[7:3];
                `CSPC_IDX_WIDTH:    width_q    <= wd_w;
                `CSPC_IDX_SYNC_CTL: sync_ctl_q <= wd_w;
                `CSPC_IDX_PWR_CTL:  pwr_ctl_q  <= wd_w;
                `CSPC_IDX_IRQ_MASK: irq_mask_q <= wd_w[NI-1:0];
                default:            ;
            endcase
        end
    end

    // ----------------------------------------
    // sync, power and interrupt state
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            power_q    <= CSPC_SEEK;
            hs_last_q  <= 1'b0;
            run_q      <= 12'h000;
            hi_len_q   <= 12'h000;
            lo_len_q   <= 12'h000;
            det_pol_q  <= 1'b0;
            det_last_q <= 1'b0;
            ref_q      <= 1'b0;
            irq_stat_q <= '0;
        end else begin
            power_q    <= power_d;
            hs_last_q  <= hs_s;
            det_pol_q  <= pol_new_w;
            det_last_q <= sync_det_w;
            // sync edges while hold is active never reach the generator
            ref_q <= hs_ref_w && !hold_act_w;
            run_q <= (hs_rise_w || hs_fall_w) ? 12'h001 :
                     (run_q == 12'hfff) ? run_q : run_q + 12'h001;
            if (hs_rise_w) begin
                lo_len_q <= run_q;
            end
            if (hs_fall_w) begin
                hi_len_q <= run_q;
            end
            // a new event beats a clear in the same cycle
            irq_stat_q <= (irq_stat_q & ~(wr_stat_w ? wd_w[NI-1:0] : '0))
                        | ev_w;
        end
    end

    // ----------------------------------------
    // pixel pipeline and sync alignment
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ck_q        <= 1'b0;
            flush_q     <= 3'h0;
            lead_pend_q <= 1'b0;
            lead_sr_q   <= '0;
            for (int i = 0; i < `CSPC_PIPE_DEPTH; i++) begin
                pipe_q[i] <= '0;
            end
        end else begin
            ck_q <= !ck_q;
            // a lead on a tick shifts in at once; pending it would start twice
            if (tick_w) begin
                lead_pend_q <= 1'b0;
            end else if (lead_w) begin
                lead_pend_q <= 1'b1;
            end
            if (power_q != CSPC_FULL) begin
                flush_q <= 3'h0;
            end else if (tick_w && !pixel_valid_out) begin
                flush_q <= flush_q + 3'h1;
            end
            if (tick_w) begin
                lead_sr_q <= {lead_sr_q[`CSPC_PIPE_DEPTH-2:0],
                              lead_pend_q || lead_w};
                pipe_q[0] <= pixel_in;
                for (int i = 1; i < `CSPC_PIPE_DEPTH; i++) begin
                    pipe_q[i] <= pipe_q[i-1];
                end
            end
        end
    end
endmodule

// ---- cspc_defines.svh ----
// register map, field positions, reset values and timing counts
`ifndef CSPC_DEFINES_SVH
`define CSPC_DEFINES_SVH

// ----------------------------------------
// register indexes, byte address = 4 * index
// ----------------------------------------
`define CSPC_IDX_DIV_MSB   8'h01
`define CSPC_IDX_DIV_LSB   8'h02
`define CSPC_IDX_PLL_CTL   8'h03
`define CSPC_IDX_PHASE     8'h04
`define CSPC_IDX_WIDTH     8'h07
`define CSPC_IDX_SYNC_CTL  8'h0e
`define CSPC_IDX_PWR_CTL   8'h0f
`define CSPC_IDX_STATUS    8'h14
`define CSPC_IDX_IRQ_STAT  8'h18
`define CSPC_IDX_IRQ_MASK  8'h19

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSPC_RST_DIV_MSB   8'h69
`define CSPC_RST_DIV_LSB   8'hd0
`define CSPC_RST_PLL_CTL   8'h08
`define CSPC_RST_PHASE     8'h40
`define CSPC_RST_WIDTH     8'h20
`define CSPC_RST_SYNC_CTL  8'h68
`define CSPC_RST_PWR_CTL   8'h02

// ----------------------------------------
// field positions, divider minimum, pipe depth and interrupt count
// ----------------------------------------
`define CSPC_BIT_OUT_POL   5
`define CSPC_BIT_HS_POL    6
`define CSPC_BIT_HOLD_POL  3
`define CSPC_BIT_PWR_ON    1
`define CSPC_BIT_ACT_HS    7
`define CSPC_BIT_ACT_VS    4
`define CSPC_BIT_ACT_GS    1
`define CSPC_BIT_DET_POL   3
`define CSPC_DIV_MIN       12'h0dd
`define CSPC_PIPE_DEPTH    4
`define CSPC_NUM_IRQ       3

// ----------------------------------------
// timing
// ----------------------------------------
`define CSPC_CLK_PERIOD_NS 10
`define CSPC_ACT_TIME_NS   1000000
`define CSPC_ACT_CYCLES    (`CSPC_ACT_TIME_NS / `CSPC_CLK_PERIOD_NS)

`endif

// ---- cspc_pkg.sv ----
// types shared by the capture sync and power control block
package cspc_pkg;
    typedef enum logic [1:0] {
        CSPC_FULL = 2'b00,
        CSPC_SEEK = 2'b01,
        CSPC_DOWN = 2'b10
    } cspc_power_type;
endpackage

// ---- cspc_sync_in.sv ----
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module cspc_sync_in #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ----------------------------------------
    // first stage feeds only the second
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ---- cspc_pulse_gen.sv ----
// sync output pulse of programmable width and polarity
`timescale 1ns/10ps
module cspc_pulse_gen #(
    parameter int CW = 8
) (
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          tick_in,
    input  wire logic          start_in,
    input  wire logic [CW-1:0] width_in,
    input  wire logic          active_high_in,
    output logic               pulse_out
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          pulse_q;
    logic          active_w;

    // width zero gives no pulse at all
    assign cnt_d = start_in ? width_in :
                   (tick_in && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    assign active_w = (cnt_d != '0);

    // ----------------------------------------
    // output flop changes only on pixel ticks
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            if (tick_in) begin
                pulse_q <= active_w ~^ active_high_in;
            end
        end
    end

    assign pulse_out = pulse_q;
endmodule

// ---- cspc_assertions.sv ----
// port checks for the capture sync and power control block
`timescale 1ns/10ps
module cspc_assertions #(parameter int DW = 24) (
    input wire logic          clk_in,
    input wire logic          rst_n_in,
    input wire logic          hsel_in,
    input wire logic [1:0]    htrans_in,
    input wire logic          hwrite_in,
    input wire logic          hready_in,
    input wire logic          hreadyout_out,
    input wire logic          hold_in,
    input wire logic [DW-1:0] pixel_out,
    input wire logic          pixel_valid_out,
    input wire logic          output_data_clock_out,
    input wire logic          pll_ref_out,
    input wire logic [1:0]    power_state_out,
    input wire logic          core_power_en_out,
    input wire logic          slicer_power_en_out
);
    // ----
    // cycles in full power, saturating
    // ----
    logic [3:0] full_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || power_state_out != 2'b00) full_q <= 4'h0;
        else if (full_q != 4'hf) full_q <= full_q + 4'h1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_down_power: assert property (
        power_state_out == 2'b10 |->
            !core_power_en_out && slicer_power_en_out
    ) else $error("power-down enables wrong");
    a_seek_power: assert property (
        power_state_out == 2'b01 |->
            !core_power_en_out && !slicer_power_en_out
    ) else $error("seek enables wrong");
    a_full_power: assert property (
        power_state_out == 2'b00 |-> core_power_en_out
    ) else $error("full power core off");
    a_clock_toggle: assert property (
        $past(rst_n_in) |->
            output_data_clock_out != $past(output_data_clock_out)
    ) else $error("data clock stalled");
    a_data_mid: assert property (
        $past(rst_n_in) && pixel_out != $past(pixel_out) |->
            !output_data_clock_out
    ) else $error("data moved on clock rise");
    a_valid_wait: assert property (
        power_state_out == 2'b00 && full_q < 4'h5 |-> !pixel_valid_out
    ) else $error("valid too early");
    a_coast_gate: assert property (
        hold_in [*6] |-> !pll_ref_out
    ) else $error("reference during hold");
    a_ref_pulse: assert property (
        pll_ref_out |=> !pll_ref_out
    ) else $error("reference pulse too long");
    a_read_wait: assert property (
        hsel_in && hready_in && htrans_in[1] && !hwrite_in |=>
            !hreadyout_out ##1 hreadyout_out
    ) else $error("read wait state wrong");
endmodule

// ---- cspc_rx_model.sv ----
// display receiver latching pixels on the output data clock
`timescale 1ns/10ps
module cspc_rx_model #(parameter int DW = 24) (
    input  wire logic          clk_in,
    input  wire logic          output_data_clock_in,
    input  wire logic          valid_in,
    input  wire logic [1:0]    state_in,
    input  wire logic [DW-1:0] pixel_in,
    output logic      [3:0]    drop_out,
    output logic      [DW-1:0] word_out
);
    logic dclk_q;
    // latch only on a rise, the data is mid-eye there
    always_ff @(posedge clk_in) begin
        dclk_q <= output_data_clock_in;
        if (state_in != 2'b00) drop_out <= 4'h0;
        else if (output_data_clock_in && !dclk_q) begin
            if (!valid_in) drop_out <= drop_out + 4'h1;
            else word_out <= pixel_in;
        end
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the capture sync and power control block
`timescale 1ns/10ps
module testbench;
    logic        clk_in, rst_n_in, hsel_in, hwrite_in, hold_in, hsync_in;
    logic        hreadyout_out, hresp_out, pixel_valid_out, pll_ref_out;
    logic        output_data_clock_out, sync_output_pulse_out, irq_out;
    logic        core_power_en_out, slicer_power_en_out, hs_on, hready_in;
    logic        vsync_in, green_embedded_sync_in;
    logic [1:0]  htrans_in, oscillator_range_code_out, power_state_out;
    logic [2:0]  hsize_in, pump_code_out;
    logic [3:0]  drop;
    logic [4:0]  phase_step_out;
    logic [12:0] pll_mult_out;
    logic [23:0] pixel_in, pixel_out, word;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
    int          miscompares, checks, cyc, hc, n;

    assign hready_in = hreadyout_out;
    assign vsync_in = 1'b0;
    assign green_embedded_sync_in = 1'b0;
    assign hsize_in = 3'b010;
    // short activity timeout keeps the run brief
    cspc_top #(.ACT_CYCLES(200)) i_cspc_top (.*);
    cspc_rx_model i_cspc_rx_model (
        .clk_in               (clk_in),
        .output_data_clock_in (output_data_clock_out),
        .valid_in             (pixel_valid_out),
        .state_in             (power_state_out),
        .pixel_in             (pixel_out),
        .drop_out             (drop),
        .word_out             (word)
    );
    // ----
    // clock, sync source, pixels, watchdog
    // ----
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        hc <= (hc == 99) ? 0 : hc + 1;
        hsync_in <= hs_on && (hc < 8);
        pixel_in <= pixel_in + 24'h1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] ix,
                       input logic [31:0] d);
        hsel_in <= 1'b1;
        htrans_in <= 2'b10;
        hwrite_in <= w;
        haddr_in <= {22'h0, ix, 2'b00};
        @(posedge clk_in);
        while (!hreadyout_out) @(posedge clk_in);
        htrans_in <= 2'b00;
        hwdata_in <= d;
        @(posedge clk_in);
        while (!hreadyout_out) @(posedge clk_in);
        rd = hrdata_out;
    endtask
    task automatic go(input logic [1:0] s);
        for (int k = 0; k < 1000 && power_state_out !== s; k++)
            @(posedge clk_in);
        chk({30'h0, power_state_out}, {30'h0, s});
    endtask
    task automatic t_regs;
        logic [7:0] ix [6] = '{8'h0e, 8'h0f, 8'h07, 8'h04, 8'h03, 8'h30};
        logic [7:0] ex [6] = '{8'h68, 8'h02, 8'h20, 8'h40, 8'h08, 8'h00};
        logic [7:0] dm [3] = '{8'h0d, 8'hff, 8'h00};
        logic [7:0] dl [3] = '{8'hd0, 8'hf0, 8'h10};
        logic [12:0] me [3] = '{13'h0de, 13'h1000, 13'h0de};
        bus(1'b1, 8'h30, 32'hff);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ix[i], 32'h0);
            chk(rd, {24'h0, ex[i]});
        end
        bus(1'b1, 8'h04, 32'hf8);
        bus(1'b1, 8'h03, 32'h28);
        @(posedge clk_in);
        chk({27'h0, phase_step_out}, 32'h1f);
        chk({27'h0, oscillator_range_code_out, pump_code_out},
            32'h5);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 8'h01, {24'h0, dm[i]});
            bus(1'b1, 8'h02, {24'h0, dl[i]});
            @(posedge clk_in);
            chk({19'h0, pll_mult_out}, {19'h0, me[i]});
        end
        $display("registers done");
    endtask
    task automatic t_power;
        chk({30'h0, power_state_out}, 32'h1);
        chk({31'h0, slicer_power_en_out}, 32'h0);
        hs_on <= 1'b1;
        go(2'b00);
        bus(1'b0, 8'h14, 32'h0);
        chk({31'h0, rd[7]}, 32'h1);
        bus(1'b1, 8'h0f, 32'h0);
        go(2'b10);
        chk({30'h0, core_power_en_out, slicer_power_en_out}, 32'h1);
        bus(1'b1, 8'h0f, 32'h2);
        go(2'b00);
        repeat (20) @(posedge clk_in);
        chk({31'h0, pixel_valid_out}, 32'h1);
        chk({28'h0, drop}, 32'h4);
        while (output_data_clock_out !== 1'b1) @(posedge clk_in);
        @(posedge clk_in);
        chk({8'h0, word}, {8'h0, pixel_in - 24'h9});
        bus(1'b0, 8'h14, 32'h0);
        chk({31'h0, rd[3]}, 32'h1);
        $display("power done");
    endtask
    task automatic t_sync;
        bus(1'b1, 8'h07, 32'h3);
        for (int p = 1; p >= 0; p--) begin
            bus(1'b1, 8'h0e, p[0] ? 32'h68 : 32'h48);
            n = 0;
            while (sync_output_pulse_out === p[0] && n < 300) begin
                @(posedge clk_in);
                n++;
            end
            while (sync_output_pulse_out !== p[0] && n < 600) begin
                @(posedge clk_in);
                n++;
            end
            chk({31'h0, output_data_clock_out}, 32'h0);
            n = 0;
            while (sync_output_pulse_out === p[0] && n < 100) begin
                @(posedge clk_in);
                n++;
            end
            chk(n, 32'h6);
        end
        $display("sync output done");
    endtask
    task automatic t_coast;
        for (int h = 1; h >= 0; h--) begin
            hold_in <= h[0];
            repeat (10) @(posedge clk_in);
            n = 0;
            repeat (400) begin
                @(posedge clk_in);
                if (pll_ref_out === 1'b1) n++;
            end
            chk(n, h[0] ? 32'h0 : 32'h4);
        end
        $display("coast done");
    endtask
    task automatic t_irq;
        bus(1'b1, 8'h19, 32'h2);
        @(posedge clk_in);
        chk({31'h0, irq_out}, 32'h0);
        hs_on <= 1'b0;
        go(2'b01);
        repeat (3) @(posedge clk_in);
        chk({31'h0, irq_out}, 32'h1);
        bus(1'b1, 8'h18, 32'h7);
        @(posedge clk_in);
        chk({31'h0, irq_out}, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        $display("interrupt done");
    endtask
    initial begin
        {hsel_in, hwrite_in, hold_in, hs_on, hsync_in} = 5'h0;
        {htrans_in, haddr_in, hwdata_in, pixel_in} = 90'h0;
        {rst_n_in, hc, cyc, miscompares, checks} = 129'h0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_regs;
        t_power;
        t_sync;
        t_coast;
        t_irq;
        final_report;
    end
endmodule
bind cspc_top cspc_assertions #(.DW(DW)) i_cspc_assertions (.*);
